/* logic/kbdsel_pkg.sv */
// constants and carrier types of the keyboard controller select register block
// Contract
// [RQ1] aux output polarity follows select bit 7
// [RQ2] select bit 6 blocks pointer clock and data
// [RQ3] pointer data to wake logic never blocked
// [RQ4] select bit 5 blocks keys clock and data
// [RQ5] keys data to wake logic never blocked
// [RQ6] default pointer irq is raw AND latched
// [RQ7] select bit set gives latched keys irq
// [RQ8] select bit 2 enables fast gate port
// [RQ9] indexes above select read back zero
// [RQ10] reserved bits 1:0 read zero, ignore writes
// [RQ11] select register clears to zero on reset
package kbdsel_pkg;
  // ---------------------------------------------------------------
  // register map (byte address = 4 * printed index)
  // ---------------------------------------------------------------
  localparam logic [7:0] SEL_IDX = 8'hf0;
  localparam logic [7:0] RSV_LO_IDX = 8'hf1;
  localparam logic [7:0] RSV_HI_IDX = 8'hff;
  localparam logic [11:0] STAT_ADDR = 12'h000;
  localparam logic [11:0] MASK_ADDR = 12'h004;
  localparam logic [11:0] PINS_ADDR = 12'h008;
  // ---------------------------------------------------------------
  // select register fields and reset values
  // ---------------------------------------------------------------
  localparam int AUX_POL_BIT = 7;
  localparam int PTR_ISO_BIT = 6;
  localparam int KEYS_ISO_BIT = 5;
  localparam int PTR_LAT_BIT = 4;
  localparam int KEYS_LAT_BIT = 3;
  localparam int GATE_EN_BIT = 2;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] SEL_WMASK = 8'hfc;
  localparam logic [1:0] EV_RST = 2'h0;
  localparam int EV_PTR = 0;
  localparam int EV_KEYS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ---------------------------------------------------------------
  // carriers from and toward the keyboard microcontroller
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ptrClk;
    logic ptrData;
    logic keysClk;
    logic keysData;
    logic pointerIrq;
    logic keysIrq;
    logic auxRaw;
  } kbdsel_pins_s;
  typedef struct packed {
    logic ptrClk;
    logic ptrData;
    logic keysClk;
    logic keysData;
  } kbdsel_lines_s;
endpackage

/* logic/kbdsel_top.sv */
// select register bank with axi4-lite slave and keyboard line gating
`timescale 1ns/1ps
module kbdsel_top
  import kbdsel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire kbdsel_pkg::kbdsel_pins_s pinsIn,
  output kbdsel_pkg::kbdsel_lines_s toCtrl,
  output logic pointerDataWake,
  output logic keysDataWake,
  output logic auxOutputLine,
  output logic pointerIrqOut,
  output logic keysIrqOut,
  output logic addressLineGateEn,
  output logic irq
);
  import kbdsel_pkg::*;

  // gated line: idle high while isolated
  function automatic logic isoLine(input logic iso, input logic v);
    return iso | v;
  endfunction

  // irq forming: latched alone or raw anded with latched
  function automatic logic irqForm(input logic useLat, input logic raw, input logic lat);
    return useLat ? lat : (raw & lat);
  endfunction

  // address decode: byte address of a printed index
  function automatic logic [11:0] idxAddr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] sel_r, sel_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [1:0] rawPrev_r, rawPrev_nxt;
  logic awHeld_r, awHeld_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [11:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  kbdsel_lines_s toCtrl_nxt;
  logic ptrWake_nxt, keysWake_nxt, aux_nxt, ptrIrq_nxt, keysIrq_nxt, gate_nxt, irq_nxt;
  logic doWrite, wrHit, rdHit;
  logic [31:0] rdVal;
  logic [1:0] evSet;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always_comb
  begin
    rdHit = 1'b1;
    rdVal = 32'h0;
    if (araddr == STAT_ADDR)
    begin
      rdVal = {30'h0, stat_r};
    end
    else if (araddr == MASK_ADDR)
    begin
      rdVal = {30'h0, mask_r};
    end
    else if (araddr == PINS_ADDR)
    begin
      rdVal = {25'h0, pinsIn};
    end
    else if (araddr == idxAddr(SEL_IDX))
    begin
      rdVal = {24'h0, sel_r & SEL_WMASK}; // see [RQ10]
    end
    else if (araddr[1:0] == 2'h0 && araddr >= idxAddr(RSV_LO_IDX) && araddr <= idxAddr(RSV_HI_IDX))
    begin
      rdVal = 32'h0; // see [RQ9]
    end
    else
    begin
      rdHit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite channels and register writes
  // ---------------------------------------------------------------
  always_comb
  begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid && !bready;
    bresp_nxt = bresp;
    sel_nxt = sel_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    rawPrev_nxt = {pinsIn.keysIrq, pinsIn.pointerIrq};
    if (awvalid && awready)
    begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid && wready)
    begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata;
      wStrb_nxt = wstrb;
    end
    doWrite = awHeld_r && wHeld_r && !bvalid;
    wrHit = awAddr_r == STAT_ADDR || awAddr_r == MASK_ADDR || awAddr_r == idxAddr(SEL_IDX)
      || (awAddr_r[1:0] == 2'h0 && awAddr_r >= idxAddr(RSV_LO_IDX) && awAddr_r <= idxAddr(RSV_HI_IDX));
    if (doWrite)
    begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wrHit ? RESP_OKAY : RESP_DECERR;
      if (wStrb_r[0])
      begin
        if (awAddr_r == idxAddr(SEL_IDX))
        begin
          sel_nxt = wData_r[7:0] & SEL_WMASK; // see [RQ10]
        end
        if (awAddr_r == MASK_ADDR)
        begin
          mask_nxt = wData_r[1:0];
        end
        if (awAddr_r == STAT_ADDR)
        begin
          stat_nxt = stat_r & ~wData_r[1:0];
        end
      end
    end
    // rising microcontroller irqs latch; set wins over clear
    evSet = {pinsIn.keysIrq, pinsIn.pointerIrq} & ~rawPrev_r;
    stat_nxt = stat_nxt | evSet;
    awready_nxt = !awHeld_nxt && !bvalid_nxt;
    wready_nxt = !wHeld_nxt && !bvalid_nxt;
    arready_nxt = !rvalid; // ready again once no read answer is pending
    rvalid_nxt = rvalid;
    rdata_nxt = rdata;
    rresp_nxt = rresp;
    if (arvalid && arready)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rdVal;
      rresp_nxt = rdHit ? RESP_OKAY : RESP_DECERR;
    end
    else if (rvalid && rready)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // register bus state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sel_r <= SEL_RST; // see [RQ11]
      mask_r <= EV_RST;
      stat_r <= EV_RST;
      rawPrev_r <= EV_RST;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 12'h0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end
    else
    begin
      sel_r <= sel_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      rawPrev_r <= rawPrev_nxt;
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      awready <= awready_nxt;
      wready <= wready_nxt;
      bvalid <= bvalid_nxt;
      bresp <= bresp_nxt;
      arready <= arready_nxt;
      rvalid <= rvalid_nxt;
      rdata <= rdata_nxt;
      rresp <= rresp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // keyboard side lines
  // ---------------------------------------------------------------
  always_comb
  begin
    toCtrl_nxt.ptrClk = isoLine(sel_r[PTR_ISO_BIT], pinsIn.ptrClk); // see [RQ2]
    toCtrl_nxt.ptrData = isoLine(sel_r[PTR_ISO_BIT], pinsIn.ptrData); // see [RQ2]
    toCtrl_nxt.keysClk = isoLine(sel_r[KEYS_ISO_BIT], pinsIn.keysClk); // see [RQ4]
    toCtrl_nxt.keysData = isoLine(sel_r[KEYS_ISO_BIT], pinsIn.keysData); // see [RQ4]
    ptrWake_nxt = pinsIn.ptrData; // see [RQ3]
    keysWake_nxt = pinsIn.keysData; // see [RQ5]
    aux_nxt = sel_r[AUX_POL_BIT] ? pinsIn.auxRaw : !pinsIn.auxRaw; // see [RQ1]
    ptrIrq_nxt = irqForm(sel_r[PTR_LAT_BIT], pinsIn.pointerIrq, stat_r[EV_PTR]); // see [RQ6]
    keysIrq_nxt = irqForm(sel_r[KEYS_LAT_BIT], pinsIn.keysIrq, stat_r[EV_KEYS]); // see [RQ7]
    gate_nxt = sel_r[GATE_EN_BIT]; // see [RQ8]
    irq_nxt = |(stat_r & mask_r);
  end

  // keyboard side output flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      toCtrl <= '1;
      pointerDataWake <= 1'b1;
      keysDataWake <= 1'b1;
      auxOutputLine <= 1'b1;
      pointerIrqOut <= 1'b0;
      keysIrqOut <= 1'b0;
      addressLineGateEn <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      toCtrl <= toCtrl_nxt;
      pointerDataWake <= ptrWake_nxt;
      keysDataWake <= keysWake_nxt;
      auxOutputLine <= aux_nxt;
      pointerIrqOut <= ptrIrq_nxt;
      keysIrqOut <= keysIrq_nxt;
      addressLineGateEn <= gate_nxt;
      irq <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_aux;
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> auxOutputLine == ($past(sel_r[AUX_POL_BIT]) ~^ $past(pinsIn.auxRaw));
  endproperty
  a_aux: assert property (p_aux) else $error("aux line polarity wrong"); // see [RQ1]

  property p_ptrIso;
    @(posedge clk_sys) disable iff (rst)
    $past(sel_r[PTR_ISO_BIT]) && !$past(rst) |-> toCtrl.ptrClk && toCtrl.ptrData;
  endproperty
  a_ptrIso: assert property (p_ptrIso) else $error("pointer lines not blocked"); // see [RQ2]

  property p_ptrWake;
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> pointerDataWake == $past(pinsIn.ptrData);
  endproperty
  a_ptrWake: assert property (p_ptrWake) else $error("pointer wake data disturbed"); // see [RQ3]

  property p_keysPass;
    @(posedge clk_sys) disable iff (rst)
    !$past(sel_r[KEYS_ISO_BIT]) && !$past(rst) |-> toCtrl.keysData == $past(pinsIn.keysData);
  endproperty
  a_keysPass: assert property (p_keysPass) else $error("keys data not passed"); // see [RQ4]

  property p_keysWake;
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> keysDataWake == $past(pinsIn.keysData);
  endproperty
  a_keysWake: assert property (p_keysWake) else $error("keys wake data disturbed"); // see [RQ5]

  property p_ptrIrq;
    @(posedge clk_sys) disable iff (rst)
    !$past(sel_r[PTR_LAT_BIT]) && !$past(rst)
      |-> pointerIrqOut == ($past(pinsIn.pointerIrq) && $past(stat_r[EV_PTR]));
  endproperty
  a_ptrIrq: assert property (p_ptrIrq) else $error("pointer irq form wrong"); // see [RQ6]

  property p_keysIrq;
    @(posedge clk_sys) disable iff (rst)
    $past(sel_r[KEYS_LAT_BIT]) && !$past(rst) |-> keysIrqOut == $past(stat_r[EV_KEYS]);
  endproperty
  a_keysIrq: assert property (p_keysIrq) else $error("keys irq not latched copy"); // see [RQ7]

  property p_gate;
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> addressLineGateEn == $past(sel_r[GATE_EN_BIT]);
  endproperty
  a_gate: assert property (p_gate) else $error("gate enable wrong"); // see [RQ8]

  sequence s_rsvRead;
    arvalid && arready && araddr >= idxAddr(RSV_LO_IDX) && araddr <= idxAddr(RSV_HI_IDX) && araddr[1:0] == 2'h0;
  endsequence
  property p_rsv;
    @(posedge clk_sys) disable iff (rst)
    s_rsvRead |=> rvalid && rdata == 32'h0 && rresp == RESP_OKAY;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved index not zero"); // see [RQ9]

  property p_resvBits;
    @(posedge clk_sys) disable iff (rst)
    sel_r[1:0] == 2'h0;
  endproperty
  a_resvBits: assert property (p_resvBits) else $error("reserved bits set"); // see [RQ10]

  property p_reset;
    @(posedge clk_sys)
    rst |=> sel_r == SEL_RST && !addressLineGateEn;
  endproperty
  a_reset: assert property (p_reset) else $error("select not cleared by reset"); // see [RQ11]
endmodule

/* tb/kbdsel_ctrl_model.sv */
// behavioural keyboard microcontroller side of the select register block
`timescale 1ns/1ps
module kbdsel_ctrl_model
  import kbdsel_pkg::*;
(
  input wire logic clk_sys,
  input wire kbdsel_pkg::kbdsel_pins_s want,
  output kbdsel_pkg::kbdsel_pins_s pinsIn
);
  // port latch: new levels appear just after a clock edge, never mid-cycle
  always @(posedge clk_sys) pinsIn <= want;
endmodule

/* tb/test_keyboard_ctrl_select_config.sv */
// self-checking bench for the keyboard controller select register block
`timescale 1ns/1ps
module test_keyboard_ctrl_select_config
  import kbdsel_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, val;
  kbdsel_pins_s want = 7'h78;
  kbdsel_pins_s pinsIn;
  kbdsel_lines_s toCtrl;
  logic pointerDataWake, keysDataWake, auxOutputLine, pointerIrqOut, keysIrqOut, addressLineGateEn, irq;
  logic [7:0] linesSeen;
  // keyboard side outputs in the order of the expected table
  assign linesSeen = {toCtrl, pointerDataWake, keysDataWake, auxOutputLine, addressLineGateEn};
  int miscompares = 0;
  int checks_done = 0;
  // select value, pin levels, expected {toCtrl, wakes, aux, gate}
  logic [7:0] tsel [5] = '{8'h00, 8'h40, 8'h20, 8'h87, 8'h64};
  logic [6:0] tpin [5] = '{7'h00, 7'h00, 7'h01, 7'h01, 7'h28};
  logic [7:0] texp [5] = '{8'h02, 8'hc2, 8'h30, 8'h03, 8'hff};
  // clock at 4 ns period
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  kbdsel_top dut (.clk_sys(clk_sys), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pinsIn(pinsIn), .toCtrl(toCtrl), .pointerDataWake(pointerDataWake),
    .keysDataWake(keysDataWake), .auxOutputLine(auxOutputLine), .pointerIrqOut(pointerIrqOut),
    .keysIrqOut(keysIrqOut), .addressLineGateEn(addressLineGateEn), .irq(irq));
  kbdsel_ctrl_model partner (.clk_sys(clk_sys), .want(want), .pinsIn(pinsIn));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // axi4-lite write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  // axi4-lite read: data and response taken at the rvalid edge
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    val = rdata;
    resp = rresp;
  endtask
  // new pin levels, then wait for model and design registers to settle
  task automatic setp(input kbdsel_pins_s v);
    @(posedge clk_sys);
    want <= v;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(12'h3c0);
    chk("sel reset", val, 32'h0);
    $display("test reset done");
    // polarity, isolation, wake paths and gate enable over a table
    for (int i = 0; i < 5; i++)
    begin
      wr(12'h3c0, {24'h0, tsel[i]});
      rd(12'h3c0);
      chk("sel readback", val, {24'h0, tsel[i] & 8'hfc});
      setp(tpin[i]);
      chk("lines", {24'h0, linesSeen}, {24'h0, texp[i]});
    end
    $display("test lines done");
    // pointer irq default form, keys irq latched-only form, mask and clear
    wr(12'h004, 32'h3);
    wr(12'h3c0, 32'h08);
    setp(7'h7e);
    chk("irqs raised", {30'h0, pointerIrqOut, keysIrqOut}, 32'h3);
    setp(7'h78);
    chk("irqs dropped", {30'h0, pointerIrqOut, keysIrqOut}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(12'h000);
    chk("status", val, 32'h3);
    wr(12'h004, 32'h0);
    setp(7'h78);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(12'h000, 32'h3);
    setp(7'h78);
    chk("keys irq cleared", {31'h0, keysIrqOut}, 32'h0);
    rd(12'h000);
    chk("status cleared", val, 32'h0);
    // other form of each: pointer latched only, keys raw and latched
    wr(12'h3c0, 32'h10);
    setp(7'h7e);
    setp(7'h78);
    chk("irqs other form", {30'h0, pointerIrqOut, keysIrqOut}, 32'h2);
    $display("test irq done");
    // reserved indexes read zero, writes there change nothing
    for (int i = 1; i < 16; i++)
    begin
      wr(12'h3c0 + 12'(4 * i), 32'hff);
      rd(12'h3c0 + 12'(4 * i));
      chk("reserved", val | {30'h0, resp}, 32'h0);
    end
    rd(12'h3c0);
    chk("sel kept", val, 32'h10);
    wr(12'h100, 32'h1);
    chk("unmapped wr", {30'h0, resp}, 32'h3);
    rd(12'h100);
    chk("unmapped rd", {30'h0, resp}, 32'h3);
    $display("test map done");
    // mid-run reset clears the select register and the gate enable output
    wr(12'h3c0, 32'h84);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("gate after reset", {31'h0, addressLineGateEn}, 32'h0);
    rd(12'h3c0);
    chk("sel after reset", val, 32'h0);
    $display("test reset again done");
    results();
  end
  // watchdog: the tests need about one microsecond
  initial
  begin
    #40000;
    miscompares++;
    results();
  end
endmodule
